// File: wdtr_pkg.sv
// Constants shared by the watchdog time-out reset block
package wdtr_pkg;

  // Register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Control register location and reset value
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h21;
  localparam logic [DATA_W-1:0] CTRL_RESET  = 8'h00;

  // Control register field positions
  localparam int SEL_LSB    = 0;
  localparam int SEL_W      = 3;
  localparam int ON_BIT     = 3;
  localparam int UNLOCK_BIT = 4;
  localparam int RSVD_LSB   = 5;
  localparam int RSVD_W     = 3;

  // Turn-off window length in system clock cycles
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;

  // System clock and watchdog oscillator rates
  localparam int CLK_FREQ_HZ = 250_000_000;
  localparam int OSC_FREQ_HZ = 1_000_000;
  localparam int OSC_DIV     = CLK_FREQ_HZ / OSC_FREQ_HZ;

  // Shortest time-out in oscillator cycles, doubled per select code
  localparam int TIMEOUT_BASE_CYCLES = 16384;

  // Counter wide enough for the longest time-out
  localparam int CNT_W = 22;

endpackage

// File: wdtr_tick_div.sv
// Divider giving a one-cycle tick at the watchdog oscillator rate
`timescale 1ns/100ps
module wdtr_tick_div #(
  parameter int DIV = 250
) (
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic arst_n_in,
  // Tick
  output logic      tick_out
);

  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } wdtr_div_st_t;

  wdtr_div_st_t st;
  wdtr_div_st_t next_st;

  always_comb begin
    next_st = st;
    next_st.tick = 1'h0;
    if (st.cnt == W'(DIV - 1)) begin
      next_st.cnt  = '0;
      next_st.tick = 1'h1;
    end else begin
      next_st.cnt = st.cnt + 1'h1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick_out = st.tick;

endmodule

// File: wdtr_watchdog.sv
// Watchdog timer with control register and time-out reset pulse
//
// Overview of operation
// [R1] The counter advances once per tick of a 1 MHz oscillator rate kept apart from bus activity.
// [R2] A restart request returns the counter to zero.
// [R3] An enabled watchdog that reaches its time-out without restart emits a device reset.
// [R4] The select field picks 16K times two to the code oscillator cycles as time-out.
// [R5] Writing one to bit 3 turns the watchdog on, writing zero turns it off if unlocked.
// [R6] A zero written to bit 3 only disables while the unlock bit is already set.
// [R7] The unlock bit clears itself four clock cycles after it was set.
// [R8] Software sets unlock and enable together in one write to open the window.
// [R9] Software writes enable zero within four clock cycles of that write.
// [R10] Bits 7 to 5 of the control register read as zero.
// [R11] Software should restart the counter before enabling the watchdog.
// [R12] Restart and enable changes reach the counter cleanly and the time-out leaves as one pulse.
//
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
module wdtr_watchdog #(
  parameter int OSC_DIV             = wdtr_pkg::OSC_DIV,
  parameter int TIMEOUT_BASE_CYCLES = wdtr_pkg::TIMEOUT_BASE_CYCLES
) (
  // Clock and reset
  input  wire logic                        ref_clk_in,
  input  wire logic                        arst_n_in,
  // Register port
  input  wire logic [wdtr_pkg::ADDR_W-1:0] reg_addr_in,
  input  wire logic [wdtr_pkg::DATA_W-1:0] reg_wdata_in,
  input  wire logic                        reg_wr_in,
  input  wire logic                        reg_rd_in,
  output logic      [wdtr_pkg::DATA_W-1:0] reg_rdata_out,
  // Restart instruction from the processor
  input  wire logic                        restart_in,
  // Status and reset request
  output logic                             watchdog_on_out,
  output logic                             wdt_reset_out
);

  localparam int CW = wdtr_pkg::CNT_W;

  typedef struct packed {
    logic                          watchdog_on;
    logic                          turnoff_unlock;
    logic [2:0]                    unlock_cnt;
    logic [wdtr_pkg::SEL_W-1:0]    timeout_select;
    logic [CW-1:0]                 cnt;
    logic                          reset_pulse;
    logic [wdtr_pkg::DATA_W-1:0]   rdata;
  } wdtr_state_t;

  wdtr_state_t st;
  wdtr_state_t next_st;

  logic                        osc_tick;
  logic                        wr_hit;
  logic                        rd_hit;
  logic [CW-1:0]               limit;
  logic [wdtr_pkg::DATA_W-1:0] ctrl_view;
  logic                        expire;

  wdtr_tick_div #(
    .DIV (OSC_DIV)
  ) u_tick (
    .ref_clk_in (ref_clk_in),
    .arst_n_in  (arst_n_in),
    .tick_out   (osc_tick)
  );

  assign wr_hit = reg_wr_in && (reg_addr_in == wdtr_pkg::CTRL_OFFSET);
  assign rd_hit = reg_rd_in && (reg_addr_in == wdtr_pkg::CTRL_OFFSET);

  // [R4] Time-out doubles per select code
  assign limit = CW'(TIMEOUT_BASE_CYCLES) << st.timeout_select;

  // [R10] Upper bits read zero
  always_comb begin
    ctrl_view = '0;
    ctrl_view[wdtr_pkg::UNLOCK_BIT] = st.turnoff_unlock;
    ctrl_view[wdtr_pkg::ON_BIT] = st.watchdog_on;
    ctrl_view[wdtr_pkg::SEL_LSB +: wdtr_pkg::SEL_W] = st.timeout_select;
  end

  // [R3] Expiry at last oscillator cycle
  assign expire = osc_tick && st.watchdog_on && !restart_in &&
                  (st.cnt >= limit - 1'h1);

  always_comb begin
    next_st = st;
    next_st.reset_pulse = 1'h0;
    next_st.rdata = '0;

    if (rd_hit) begin
      next_st.rdata = ctrl_view;
    end

    // [R7] Window closes after four cycles
    if (st.turnoff_unlock) begin
      if (st.unlock_cnt == 3'h1) begin
        next_st.turnoff_unlock = 1'h0;
        next_st.unlock_cnt = 3'h0;
      end else begin
        next_st.unlock_cnt = st.unlock_cnt - 3'h1;
      end
    end

    if (wr_hit) begin
      next_st.timeout_select =
        reg_wdata_in[wdtr_pkg::SEL_LSB +: wdtr_pkg::SEL_W];
      // [R5] Enable set by write
      if (reg_wdata_in[wdtr_pkg::ON_BIT]) begin
        next_st.watchdog_on = 1'h1;
      // [R6] Clear only while unlocked
      end else if (st.turnoff_unlock) begin
        next_st.watchdog_on = 1'h0;
      end
      // [R7] Setting unlock starts its window
      if (reg_wdata_in[wdtr_pkg::UNLOCK_BIT]) begin
        next_st.turnoff_unlock = 1'h1;
        next_st.unlock_cnt = wdtr_pkg::UNLOCK_CYCLES;
      end else begin
        next_st.turnoff_unlock = 1'h0;
        next_st.unlock_cnt = 3'h0;
      end
    end

    // [R2] Restart wins over counting
    if (restart_in) begin
      next_st.cnt = '0;
    // [R12] Expiry leaves as a single pulse
    end else if (expire) begin
      next_st.cnt = '0;
      next_st.reset_pulse = 1'h1;
    // [R1] Advance once per oscillator tick
    end else if (osc_tick && st.watchdog_on) begin
      next_st.cnt = st.cnt + 1'h1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata_out   = st.rdata;
  assign watchdog_on_out = st.watchdog_on;
  assign wdt_reset_out   = st.reset_pulse;

  // Checks on the control register and counter

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  a_rsvd_read_zero: assert property ( // [R10]
    rd_hit |=> reg_rdata_out[wdtr_pkg::RSVD_LSB +: wdtr_pkg::RSVD_W] == '0
  ) else $error("Reserved bits read nonzero");

  a_read_fields: assert property ( // [R10]
    rd_hit && !wr_hit |=> reg_rdata_out == $past(ctrl_view)
  ) else $error("Control read data wrong");

  a_unlock_opens: assert property ( // [R7]
    wr_hit && reg_wdata_in[wdtr_pkg::UNLOCK_BIT] |=> st.turnoff_unlock
  ) else $error("Unlock bit not set by write");

  a_unlock_holds: assert property ( // [R7]
    wr_hit && reg_wdata_in[wdtr_pkg::UNLOCK_BIT] ##1 (!wr_hit)[*3]
      |-> st.turnoff_unlock
  ) else $error("Unlock window closed early");

  a_unlock_expires: assert property ( // [R7]
    wr_hit && reg_wdata_in[wdtr_pkg::UNLOCK_BIT] ##1 (!wr_hit)[*4]
      |=> !st.turnoff_unlock
  ) else $error("Unlock window stayed open");

  a_enable_sets: assert property ( // [R5]
    wr_hit && reg_wdata_in[wdtr_pkg::ON_BIT] |=> watchdog_on_out
  ) else $error("Enable write ignored");

  a_disable_locked: assert property ( // [R6]
    wr_hit && !reg_wdata_in[wdtr_pkg::ON_BIT] && !st.turnoff_unlock &&
    st.watchdog_on |=> watchdog_on_out
  ) else $error("Watchdog disabled without unlock");

  a_disable_open: assert property ( // [R6]
    wr_hit && !reg_wdata_in[wdtr_pkg::ON_BIT] && st.turnoff_unlock
      |=> !watchdog_on_out
  ) else $error("Unlocked disable ignored");

  a_restart_clears: assert property ( // [R2]
    restart_in |=> st.cnt == '0 && !wdt_reset_out
  ) else $error("Restart did not clear counter");

  a_count_on_tick: assert property ( // [R1]
    !osc_tick && !restart_in |=> $stable(st.cnt)
  ) else $error("Counter moved without oscillator tick");

  a_timeout_fires: assert property ( // [R4]
    osc_tick && st.watchdog_on && !restart_in &&
    st.cnt == limit - 1'h1 |=> wdt_reset_out && st.cnt == '0
  ) else $error("Time-out did not fire at selected count");

  a_reset_cause: assert property ( // [R3]
    wdt_reset_out |-> $past(st.watchdog_on) && $past(osc_tick)
  ) else $error("Reset pulse without enabled expiry");

  a_reset_single: assert property ( // [R12]
    wdt_reset_out |=> !wdt_reset_out
  ) else $error("Reset pulse longer than one cycle");

  a_rdata_idle: assert property ( // [R10]
    !rd_hit |=> reg_rdata_out == '0
  ) else $error("Read data not idle");

  a_select_written: assert property ( // [R4]
    wr_hit |=> st.timeout_select ==
      $past(reg_wdata_in[wdtr_pkg::SEL_LSB +: wdtr_pkg::SEL_W])
  ) else $error("Select field not written");

  a_select_held: assert property ( // [R4]
    !wr_hit |=> $stable(st.timeout_select)
  ) else $error("Select field changed without write");

  a_on_held: assert property ( // [R5]
    !wr_hit |=> $stable(watchdog_on_out)
  ) else $error("Enable changed without write");

  a_enable_needs_write: assert property ( // [R5]
    $rose(watchdog_on_out) |-> $past(wr_hit)
  ) else $error("Enable rose without write");

  a_disable_needs_unlock: assert property ( // [R6]
    $fell(watchdog_on_out) |-> $past(wr_hit) && $past(st.turnoff_unlock)
  ) else $error("Enable fell without unlocked write");

  a_unlock_write_zero: assert property ( // [R7]
    wr_hit && !reg_wdata_in[wdtr_pkg::UNLOCK_BIT] |=> !st.turnoff_unlock
  ) else $error("Unlock bit not cleared by write");

  a_unlock_sw_only: assert property ( // [R7]
    !wr_hit && !st.turnoff_unlock |=> !st.turnoff_unlock
  ) else $error("Unlock bit set without write");

  a_unlock_reload: assert property ( // [R7]
    wr_hit && reg_wdata_in[wdtr_pkg::UNLOCK_BIT]
      |=> st.unlock_cnt == wdtr_pkg::UNLOCK_CYCLES
  ) else $error("Unlock window not reloaded");

  a_unlock_count_range: assert property ( // [R7]
    st.turnoff_unlock |-> st.unlock_cnt != 3'h0 &&
      st.unlock_cnt <= wdtr_pkg::UNLOCK_CYCLES
  ) else $error("Unlock window count out of range");

  a_unlock_cnt_idle: assert property ( // [R7]
    !st.turnoff_unlock |-> st.unlock_cnt == 3'h0
  ) else $error("Unlock window count left over");

  a_count_held_off: assert property ( // [R5]
    !st.watchdog_on && !restart_in |=> $stable(st.cnt)
  ) else $error("Counter moved while disabled");

  a_count_step: assert property ( // [R1]
    osc_tick && st.watchdog_on && !restart_in && !expire
      |=> st.cnt == $past(st.cnt) + 1'h1
  ) else $error("Counter did not advance on tick");

  a_tick_gap: assert property ( // [R1]
    OSC_DIV > 1 && osc_tick |=> !osc_tick
  ) else $error("Oscillator tick longer than one cycle");

  a_no_reset_off: assert property ( // [R3]
    !st.watchdog_on |=> !wdt_reset_out
  ) else $error("Reset pulse while disabled");

  a_pulse_clears_count: assert property ( // [R3]
    wdt_reset_out |-> st.cnt == '0
  ) else $error("Counter not cleared with reset pulse");

  a_no_early_reset: assert property ( // [R4]
    wdt_reset_out |-> $past(st.cnt) >= $past(limit) - 1'h1
  ) else $error("Reset pulse before time-out");

  a_reset_no_restart: assert property ( // [R2]
    wdt_reset_out |-> !$past(restart_in)
  ) else $error("Reset pulse despite restart");

  c_timeout: cover property (
    wdt_reset_out
  );

  c_disable_sequence: cover property (
    wr_hit && reg_wdata_in[wdtr_pkg::UNLOCK_BIT] &&
    reg_wdata_in[wdtr_pkg::ON_BIT] ##[1:4]
    wr_hit && !reg_wdata_in[wdtr_pkg::ON_BIT] ##1 !watchdog_on_out
  );

  c_restart_running: cover property (
    st.watchdog_on && st.cnt != '0 && restart_in
  );

  c_late_disable: cover property (
    st.watchdog_on && wr_hit && !reg_wdata_in[wdtr_pkg::ON_BIT] &&
    !st.turnoff_unlock
  );

  c_select_max: cover property (
    wdt_reset_out && st.timeout_select == 3'h7
  );

endmodule

// File: wdtr_tb.sv
// Self-checking testbench for the watchdog time-out reset block
`timescale 1ns/100ps
module testbench;
  localparam int DIV  = 2;
  localparam int BASE = 4;
  logic       ref_clk_in;
  logic       arst_n_in;
  logic [7:0] reg_addr_in;
  logic [7:0] reg_wdata_in;
  logic       reg_wr_in;
  logic       reg_rd_in;
  logic [7:0] reg_rdata_out;
  logic       restart_in;
  logic       watchdog_on_out;
  logic       wdt_reset_out;
  int         n_fail;
  int         num_checks;
  int         n_pulse;

  wdtr_watchdog #(.OSC_DIV(DIV), .TIMEOUT_BASE_CYCLES(BASE)) wdtr_watchdog_i (
    .ref_clk_in      (ref_clk_in),
    .arst_n_in       (arst_n_in),
    .reg_addr_in     (reg_addr_in),
    .reg_wdata_in    (reg_wdata_in),
    .reg_wr_in       (reg_wr_in),
    .reg_rd_in       (reg_rd_in),
    .reg_rdata_out   (reg_rdata_out),
    .restart_in      (restart_in),
    .watchdog_on_out (watchdog_on_out),
    .wdt_reset_out   (wdt_reset_out)
  );

  initial begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end

  always @(posedge ref_clk_in) begin
    if (wdt_reset_out === 1'b1) n_pulse++;
  end

  task automatic results();
    if (n_fail == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_in    <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_in   <= 1'b0;
    #1;
    chk("read data", exp, reg_rdata_out);
    @(posedge ref_clk_in);
    #1;
    chk("read idle", 8'h00, reg_rdata_out);
  endtask

  task automatic restart();
    @(posedge ref_clk_in);
    restart_in <= 1'b1;
    @(posedge ref_clk_in);
    restart_in <= 1'b0;
  endtask

  // Restart, then measure edges until the reset pulse
  task automatic expire(int lim);
    int n;
    n = 0;
    restart();
    #1;
    while (wdt_reset_out !== 1'b1) begin
      if (n > lim * DIV + 8) begin
        n_fail++;
        $display("Error timeout pulse expected %0d seen none", lim);
        results();
      end
      @(posedge ref_clk_in);
      #1;
      n++;
    end
    num_checks++;
    if (n < (lim - 1) * DIV + 1 || n > lim * DIV) begin
      n_fail++;
      $display("Error timeout edges expected %0d seen %0d", lim * DIV, n);
    end
    @(posedge ref_clk_in);
    #1;
    chk("pulse width", 8'h00, {7'h00, wdt_reset_out});
  endtask

  initial begin
    arst_n_in    = 1'b0;
    reg_addr_in  = 8'h00;
    reg_wdata_in = 8'h00;
    reg_wr_in    = 1'b0;
    reg_rd_in    = 1'b0;
    restart_in   = 1'b0;
    n_fail       = 0;
    num_checks   = 0;
    n_pulse      = 0;
    repeat (2) @(posedge ref_clk_in);
    arst_n_in <= 1'b1;
    rd(8'h21, 8'h00);
    wr(8'h22, 8'hff);
    rd(8'h20, 8'h00);
    rd(8'h21, 8'h00);
    wr(8'h21, 8'hff);
    rd(8'h21, 8'h1f);
    repeat (3) @(posedge ref_clk_in);
    rd(8'h21, 8'h0f);
    wr(8'h21, 8'h00);
    #1;
    chk("locked off", 8'h01, {7'h00, watchdog_on_out});
    rd(8'h21, 8'h08);
    wr(8'h21, 8'h18);
    repeat (3) @(posedge ref_clk_in);
    wr(8'h21, 8'h00);
    #1;
    chk("late off", 8'h01, {7'h00, watchdog_on_out});
    wr(8'h21, 8'h18);
    repeat (2) @(posedge ref_clk_in);
    wr(8'h21, 8'h00);
    #1;
    chk("on state", 8'h00, {7'h00, watchdog_on_out});
    restart();
    for (int s = 0; s < 8; s++) begin
      wr(8'h21, 8'h08 | s[7:0]);
      expire(BASE << s);
    end
    wr(8'h21, 8'h08);
    n_pulse = 0;
    repeat (12) restart();
    chk("kept alive", 8'h00, n_pulse[7:0]);
    wr(8'h21, 8'h18);
    wr(8'h21, 8'h00);
    repeat (100) @(posedge ref_clk_in);
    chk("off pulses", 8'h00, n_pulse[7:0]);
    wr(8'h21, 8'h0d);
    @(posedge ref_clk_in);
    arst_n_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    chk("reset on", 8'h00, {7'h00, watchdog_on_out});
    arst_n_in <= 1'b1;
    rd(8'h21, 8'h00);
    results();
  end

  initial begin
    #200000;
    n_fail++;
    $display("Error run time expected end seen hang");
    results();
  end
endmodule
